// file: inc/sbsd_defs.svh
// constants for the synchronous burst sram cycle decoder
// assumes: included by bare name from package and design modules
`ifndef SBSD_DEFS_SVH
`define SBSD_DEFS_SVH

// ----------------------------------------
// array geometry
// ----------------------------------------
`define SBSD_ADDR_W      20
`define SBSD_LANES       4
`define SBSD_LANE_BITS   8
`define SBSD_BURST_W     2

// ----------------------------------------
// mode input encoding (mode low selects linear)
// ----------------------------------------
`define SBSD_MODE_LINEAR 1'b0

// ----------------------------------------
// reset values
// ----------------------------------------
`define SBSD_DRIVE_RST   1'b0
`define SBSD_COUNT_RST   2'h0

`endif

// file: inc/sbsd_pkg.sv
// types shared by the cycle decoder modules
// assumes: sbsd_defs.svh on the include path
`include "sbsd_defs.svh"

package sbsd_pkg;

    // ----------------------------------------
    // cycle kinds, gray in declaration order
    // ----------------------------------------
    typedef enum logic [2:0] {
        SBSD_DESELECT = 3'h0,
        SBSD_BEGIN_RD = 3'h1,
        SBSD_BEGIN_WR = 3'h3,
        SBSD_CONT_RD  = 3'h2,
        SBSD_CONT_WR  = 3'h6,
        SBSD_SUSP_RD  = 3'h7,
        SBSD_SUSP_WR  = 3'h5,
        SBSD_SLEEP    = 3'h4
    } sbsd_op_type;

    typedef logic [`SBSD_BURST_W-1:0] sbsd_burst_type;

endpackage

// file: inc/sbsd_burst_if.sv
// burst counter hand-off between decoder and counter
// assumes: counter and decoder share one clock
`timescale 1ns/1ps
`default_nettype none

interface sbsd_burst_if;
    import sbsd_pkg::*;

    logic           load;
    logic           advance;
    logic           interleaved;
    sbsd_burst_type startLow;
    sbsd_burst_type curLow;
    sbsd_burst_type nextLow;

    modport ctrl    (output load, advance, interleaved, startLow,
                     input  curLow, nextLow);
    modport counter (input  load, advance, interleaved, startLow,
                     output curLow, nextLow);
endinterface

`default_nettype wire

// file: logic/sbsd_burst_counter.sv
// two-bit wraparound burst counter, interleaved or linear
// assumes: load and advance are never both high
`timescale 1ns/1ps
`default_nettype none
`include "sbsd_defs.svh"

module sbsd_burst_counter
    import sbsd_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // decoder side
    sbsd_burst_if.counter burst
);

    sbsd_burst_type countReg;
    sbsd_burst_type startReg;
    sbsd_burst_type countNext;

    // ----------------------------------------
    // step count and origin
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            countReg <= `SBSD_COUNT_RST;
            startReg <= `SBSD_COUNT_RST;
        end else if (burst.load) begin
            countReg <= `SBSD_COUNT_RST;
            startReg <= burst.startLow;
        end else if (burst.advance) begin
            countReg <= countNext;
        end
    end

    // wraps at four; interleave is xor, linear is add
    always_comb begin
        countNext = countReg + 2'h1;
        if (burst.interleaved) begin
            burst.curLow  = startReg ^ countReg;
            burst.nextLow = startReg ^ countNext;
        end else begin
            burst.curLow  = startReg + countReg;
            burst.nextLow = startReg + countNext;
        end
    end

endmodule

`default_nettype wire

// file: logic/sbsd_lane_write.sv
// combined write and per-lane write mask decode
// assumes: write controls sampled on the same edge as the cycle
`timescale 1ns/1ps
`default_nettype none
`include "sbsd_defs.svh"

module sbsd_lane_write
    import sbsd_pkg::*;
#(
    parameter int LANES = `SBSD_LANES
) (
    // write controls, active low
    input  wire logic             globalWriteN,
    input  wire logic             byteWriteGateN,
    input  wire logic [LANES-1:0] laneWriteN,
    // decoded
    output logic                  writeActive,
    output logic [LANES-1:0]      laneMask
);

    // ----------------------------------------
    // one lane per generate step
    // ----------------------------------------
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        // global write forces every lane on
        assign laneMask[i] = ~globalWriteN |
                             (~byteWriteGateN & ~laneWriteN[i]);
    end

    // inactive when global write is high and either the gate or every lane control is high
    assign writeActive = |laneMask;

endmodule

`default_nettype wire

// file: logic/sbsd_cycle_decode.sv
// cycle decoder and array of a pipelined synchronous burst sram
// assumes: all inputs synchronous to ref_clk except outEnN;
// the bus master drives the data pins only while dataOeN is high
//
// Function
// - controller strobe, write inactive: read begins
// - processor strobe begin is always read
// - controller strobe, write active: write begins
// - writes only after processor begin or controller
// - no strobe, advance low, read: next address
// - no strobe, advance low, write: next address
// - advance high holds address, read or write
// - write active: global or gate plus lane
// - write inactive when global high and gate or all lanes high
// - any lane combination accepted at once
// - only selected lanes and parity updated
// - output enable acts without the clock
// - writes keep data drivers off
// - read drives bus when output enable low
// - deselect tri-states outputs at the next clock edge
// - sleep overrides everything, keeps contents
// - two-bit burst counter, interleaved or linear
// - global write writes all four lanes
`timescale 1ns/1ps
`default_nettype none
`include "sbsd_defs.svh"

module sbsd_cycle_decode
    import sbsd_pkg::*;
#(
    parameter int ADDR_W    = `SBSD_ADDR_W,
    parameter int LANES     = `SBSD_LANES,
    parameter int LANE_BITS = `SBSD_LANE_BITS
) (
    // clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         srst,
    // selects and sleep
    input  wire logic                         primary_select_n,
    input  wire logic                         expansion_select_hi,
    input  wire logic                         expansion_select_lo_n,
    input  wire logic                         sleep_request,
    // burst control
    input  wire logic                         processor_addr_strobe_n,
    input  wire logic                         controller_addr_strobe_n,
    input  wire logic                         burst_advance_n,
    input  wire logic                         burstMode,
    input  wire logic [ADDR_W-1:0]            addr,
    // write control
    input  wire logic                         global_write_n,
    input  wire logic                         byte_write_gate_n,
    input  wire logic [LANES-1:0]             lane_write_n,
    // output enable, not clocked
    input  wire logic                         outEnN,
    // data pins as input, output and enable
    input  wire logic [LANES*LANE_BITS-1:0]   dataIn,
    output logic      [LANES*LANE_BITS-1:0]   dataOut,
    output logic                              dataOeN,
    input  wire logic [LANES-1:0]             parity_ioIn,
    output logic      [LANES-1:0]             parity_ioOut,
    output logic                              parity_ioOeN,
    // observed cycle kind
    output sbsd_op_type                       cycleOp
);

    localparam int DEPTH = 2 ** ADDR_W;
    localparam int BW    = `SBSD_BURST_W;

    // ----------------------------------------
    // storage and state
    // ----------------------------------------
    sbsd_op_type                   opReg;
    sbsd_op_type                   opNext;
    logic                          driveReg;
    logic [ADDR_W-1:0]             baseReg;
    logic [ADDR_W-1:0]             addrUsed;
    logic [LANES*LANE_BITS-1:0]    dataOutReg;
    logic [LANES-1:0]              parityOutReg;

    // decode terms
    logic                          allSelected;
    logic                          deselectHit;
    logic                          beginProc;
    logic                          beginCtrl;
    logic                          continueHit;
    logic                          writeActive;
    logic [LANES-1:0]              laneMask;
    logic                          isWrite;
    logic                          isRead;

    sbsd_burst_if burst ();

    // ----------------------------------------
    // submodules
    // ----------------------------------------
    sbsd_lane_write #(
        .LANES          (LANES)
    ) u_lane_write (
        .globalWriteN   (global_write_n),
        .byteWriteGateN (byte_write_gate_n),
        .laneWriteN     (lane_write_n),
        .writeActive    (writeActive),
        .laneMask       (laneMask)
    );

    sbsd_burst_counter u_burst_counter (
        .ref_clk        (ref_clk),
        .srst           (srst),
        .burst          (burst.counter)
    );

    // ----------------------------------------
    // strobe decode
    // ----------------------------------------
    // all three enables active
    assign allSelected = ~primary_select_n & expansion_select_hi
                         & ~expansion_select_lo_n;

    // processor strobe is ignored while the primary enable is high
    assign deselectHit =
        (primary_select_n & ~controller_addr_strobe_n) |
        (~primary_select_n & ~(expansion_select_hi & ~expansion_select_lo_n)
         & (~processor_addr_strobe_n | ~controller_addr_strobe_n));

    assign beginProc   = allSelected & ~processor_addr_strobe_n;
    assign beginCtrl   = allSelected & processor_addr_strobe_n
                         & ~controller_addr_strobe_n;
    assign continueHit = controller_addr_strobe_n
                         & (processor_addr_strobe_n | primary_select_n);

    // ----------------------------------------
    // cycle selection
    // ----------------------------------------
    // sleep first, then deselect, then begin, then burst
    always_comb begin
        opNext = SBSD_DESELECT;
        if (sleep_request) begin
            opNext = SBSD_SLEEP;
        end else if (deselectHit) begin
            opNext = SBSD_DESELECT;
        end else if (beginProc) begin
            opNext = SBSD_BEGIN_RD;
        end else if (beginCtrl) begin
            opNext = writeActive ? SBSD_BEGIN_WR
                                 : SBSD_BEGIN_RD;
        end else if (continueHit) begin
            if (!burst_advance_n) begin
                opNext = writeActive ? SBSD_CONT_WR
                                     : SBSD_CONT_RD;
            end else begin
                opNext = writeActive ? SBSD_SUSP_WR
                                     : SBSD_SUSP_RD;
            end
        end
    end

    // writes only from a controller begin or a following burst cycle
    assign isWrite = (opNext == SBSD_BEGIN_WR) | (opNext == SBSD_CONT_WR)
                     | (opNext == SBSD_SUSP_WR);
    assign isRead  = (opNext == SBSD_BEGIN_RD) | (opNext == SBSD_CONT_RD)
                     | (opNext == SBSD_SUSP_RD);

    // ----------------------------------------
    // address path
    // ----------------------------------------
    // burst cycles keep the upper bits of the last begin address
    always_comb begin
        unique case (opNext)
            SBSD_BEGIN_RD,
            SBSD_BEGIN_WR: addrUsed = addr;
            SBSD_CONT_RD,
            SBSD_CONT_WR:  addrUsed = {baseReg[ADDR_W-1:BW],
                                       burst.nextLow};
            SBSD_SUSP_RD,
            SBSD_SUSP_WR:  addrUsed = {baseReg[ADDR_W-1:BW],
                                       burst.curLow};
            SBSD_DESELECT,
            SBSD_SLEEP:    addrUsed = baseReg;
        endcase
    end

    // counter load on begin, step on continue
    assign burst.load        = (opNext == SBSD_BEGIN_RD)
                               | (opNext == SBSD_BEGIN_WR);
    assign burst.advance     = (opNext == SBSD_CONT_RD)
                               | (opNext == SBSD_CONT_WR);
    assign burst.startLow    = addr[BW-1:0];
    assign burst.interleaved = (burstMode != `SBSD_MODE_LINEAR);

    // upper address bits held for the whole burst
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            baseReg <= '0;
        end else if (burst.load) begin
            baseReg <= addr;
        end
    end

    // ----------------------------------------
    // per-lane array and read pipeline
    // ----------------------------------------
    // no reset on the array: contents survive sleep and reset;
    // each lane owns its array so a single process writes it
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        // one lane is its data byte plus its parity bit
        logic [LANE_BITS:0]   laneMem [DEPTH];
        logic [LANE_BITS-1:0] laneOut;
        logic                 laneParity;

        always_ff @(posedge ref_clk) begin
            if (!srst && isWrite && laneMask[i]) begin
                laneMem[addrUsed] <=
                    {parity_ioIn[i],
                     dataIn[i*LANE_BITS +: LANE_BITS]};
            end
        end

        // output register gives data just after the same edge that samples the cycle
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                laneOut    <= '0;
                laneParity <= 1'b0;
            end else if (isRead) begin
                laneOut    <= laneMem[addrUsed][LANE_BITS-1:0];
                laneParity <= laneMem[addrUsed][LANE_BITS];
            end
        end

        assign dataOutReg[i*LANE_BITS +: LANE_BITS] = laneOut;
        assign parityOutReg[i]                      = laneParity;
    end

    // drivers may turn on only after a read edge
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            driveReg <= `SBSD_DRIVE_RST;
        end else begin
            // write, deselect and sleep all drop it at the edge
            driveReg <= isRead;
        end
    end

    // cycle kind for observation
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            opReg <= SBSD_DESELECT;
        end else begin
            opReg <= opNext;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // enable gated with the raw output enable, so it acts
    // without waiting for an edge; sleep cuts it the same way
    assign dataOeN      = ~(driveReg & ~outEnN & ~sleep_request);
    assign parity_ioOeN = ~(driveReg & ~outEnN & ~sleep_request);
    assign dataOut      = dataOutReg;
    assign parity_ioOut = parityOutReg;
    assign cycleOp      = opReg;

endmodule

`default_nettype wire

// file: tb/sbsd_cycle_decode_assertions.sv
// port assertions for the burst sram cycle decoder
// assumes: bound into every sbsd_cycle_decode instance
`timescale 1ns/1ps
`default_nettype none

module sbsd_cycle_decode_assertions
    import sbsd_pkg::*;
#(
    parameter int LANES = 4
) (
    // clock and reset
    input wire logic             ref_clk,
    input wire logic             srst,
    // sampled controls
    input wire logic             primary_select_n,
    input wire logic             expansion_select_hi,
    input wire logic             expansion_select_lo_n,
    input wire logic             sleep_request,
    input wire logic             processor_addr_strobe_n,
    input wire logic             controller_addr_strobe_n,
    input wire logic             burst_advance_n,
    input wire logic             global_write_n,
    input wire logic             byte_write_gate_n,
    input wire logic [LANES-1:0] lane_write_n,
    input wire logic             outEnN,
    // results
    input wire logic             dataOeN,
    input wire sbsd_op_type      cycleOp
);
    // ----
    // decoded conditions
    // ----
    logic wrAct;
    logic selOn;
    assign wrAct = !global_write_n || (!byte_write_gate_n && !(&lane_write_n));
    assign selOn = !sleep_request && !primary_select_n && expansion_select_hi && !expansion_select_lo_n;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // begin and burst steps; sleep wins over all of them
    sequence procBegin;
        selOn && !processor_addr_strobe_n;
    endsequence
    sequence ctrlBegin;
        selOn && processor_addr_strobe_n && !controller_addr_strobe_n;
    endsequence
    sequence burstStep;
        !sleep_request && controller_addr_strobe_n && (processor_addr_strobe_n || primary_select_n);
    endsequence

    proc_begin_rd_a: assert property (procBegin |=> cycleOp == SBSD_BEGIN_RD)
        else $error("processor begin not a read");
    ctrl_begin_wr_a: assert property (ctrlBegin ##0 wrAct |=> cycleOp == SBSD_BEGIN_WR)
        else $error("controller begin write missed");
    ctrl_begin_rd_a: assert property (ctrlBegin ##0 !wrAct |=> cycleOp == SBSD_BEGIN_RD)
        else $error("controller begin read missed");
    next_read_a: assert property (burstStep ##0 !burst_advance_n && !wrAct |=> cycleOp == SBSD_CONT_RD)
        else $error("continue read missed");
    next_write_a: assert property (burstStep ##0 !burst_advance_n && wrAct |=> cycleOp == SBSD_CONT_WR)
        else $error("continue write missed");
    hold_write_a: assert property (burstStep ##0 burst_advance_n && wrAct |=> cycleOp == SBSD_SUSP_WR)
        else $error("suspend write missed");
    deselect_off_a: assert property (!sleep_request && primary_select_n && !controller_addr_strobe_n
        |=> cycleOp == SBSD_DESELECT && dataOeN) else $error("deselect not taken");
    sleep_off_a: assert property (sleep_request |-> dataOeN ##1 cycleOp == SBSD_SLEEP)
        else $error("sleep not taken");
    oe_gate_a: assert property (outEnN |-> dataOeN)
        else $error("drivers on with enable high");
    write_quiet_a: assert property (cycleOp inside {SBSD_BEGIN_WR, SBSD_CONT_WR, SBSD_SUSP_WR} |-> dataOeN)
        else $error("drivers on in write");
    read_drive_a: assert property (cycleOp inside {SBSD_BEGIN_RD, SBSD_CONT_RD, SBSD_SUSP_RD}
        && !outEnN && !sleep_request |-> !dataOeN) else $error("read not driven");
endmodule

bind sbsd_cycle_decode sbsd_cycle_decode_assertions #(.LANES(LANES)) sbsd_cycle_decode_assertions_inst (
    .ref_clk(ref_clk),
    .srst(srst),
    .primary_select_n(primary_select_n),
    .expansion_select_hi(expansion_select_hi),
    .expansion_select_lo_n(expansion_select_lo_n),
    .sleep_request(sleep_request),
    .processor_addr_strobe_n(processor_addr_strobe_n),
    .controller_addr_strobe_n(controller_addr_strobe_n),
    .burst_advance_n(burst_advance_n),
    .global_write_n(global_write_n),
    .byte_write_gate_n(byte_write_gate_n),
    .lane_write_n(lane_write_n),
    .outEnN(outEnN),
    .dataOeN(dataOeN),
    .cycleOp(cycleOp)
);

`default_nettype wire

// file: tb/sbsd_bus_master_model.sv
// shared data and parity pins as the bus master sees them
// assumes: master drives only in write cycles, with outEnN high
`timescale 1ns/1ps
`default_nettype none

module sbsd_bus_master_model (
    // clock
    input  wire logic        ref_clk,
    // master side
    input  wire logic        masterDrive,
    input  wire logic [35:0] wrWord,
    // device pins
    input  wire logic [31:0] dataOut,
    input  wire logic        dataOeN,
    input  wire logic [3:0]  parityOut,
    input  wire logic        parityOeN,
    output logic      [35:0] busLevel
);
    logic [35:0] lastLevel = 36'h0;
    // a released bus floats: show the inverse so stale data never matches
    assign busLevel[31:0] = !dataOeN ? dataOut : masterDrive ? wrWord[31:0] : ~lastLevel[31:0];
    assign busLevel[35:32] = !parityOeN ? parityOut : masterDrive ? wrWord[35:32] : ~lastLevel[35:32];
    always_ff @(posedge ref_clk) begin
        lastLevel <= busLevel;
    end
endmodule

`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the burst sram cycle decoder
// assumes: inputs change 1 ns after each rising edge, except in t_offs where enable changes 1 and 2 ns, sleep 2 ns and the sleep cycle's inputs 3 ns after it
`timescale 1ns/1ps
`default_nettype none

module tb
    import sbsd_pkg::*;
;
    logic clk, srst, s1N, s2, s3N, zz, pN, cN, vN, md, gN, bN, oeN, drv;
    logic [3:0] lN;
    logic [7:0] a;
    logic [35:0] wr, bus;
    logic [35:0] memModel [256];
    logic [31:0] dOut;
    logic [3:0] pOut;
    logic dOeN, pOeN;
    sbsd_op_type op;
    int err_count, tests_run;

    sbsd_cycle_decode #(.ADDR_W(8)) sbsd_cycle_decode_inst (
        .ref_clk(clk), .srst(srst), .primary_select_n(s1N), .expansion_select_hi(s2),
        .expansion_select_lo_n(s3N), .sleep_request(zz), .processor_addr_strobe_n(pN),
        .controller_addr_strobe_n(cN), .burst_advance_n(vN), .burstMode(md), .addr(a),
        .global_write_n(gN), .byte_write_gate_n(bN), .lane_write_n(lN), .outEnN(oeN),
        .dataIn(bus[31:0]), .dataOut(dOut), .dataOeN(dOeN), .parity_ioIn(bus[35:32]),
        .parity_ioOut(pOut), .parity_ioOeN(pOeN), .cycleOp(op)
    );
    sbsd_bus_master_model sbsd_bus_master_model_inst (
        .ref_clk(clk), .masterDrive(drv), .wrWord(wr), .dataOut(dOut), .dataOeN(dOeN),
        .parityOut(pOut), .parityOeN(pOeN), .busLevel(bus)
    );

    // ----
    // shared tasks
    // ----
    task automatic chk(input logic [35:0] got, input logic [35:0] want);
        tests_run++;
        if (got !== want) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
            err_count++;
        end
    endtask

    // one cycle; the model keeps the lanes a write should touch
    task automatic cyc(input logic p, c, v, g, b, input logic [3:0] l, input logic [7:0] ad,
                       input logic [35:0] w);
        logic wrOn;
        wrOn = !zz && p && (!g || (!b && !(&l))) && (c || (!s1N && s2 && !s3N));
        pN = p;
        cN = c;
        vN = v;
        gN = g;
        bN = b;
        lN = l;
        a = ad;
        wr = w;
        drv = wrOn;
        oeN = wrOn;
        @(posedge clk);
        #1;
        for (int i = 0; i < 4; i++) begin
            if (wrOn && (!g || !l[i])) begin
                memModel[ad][8*i +: 8] = w[8*i +: 8];
                memModel[ad][32+i] = w[32+i];
            end
        end
    endtask

    task automatic rd(input logic [7:0] ad);
        cyc(1, 0, 1, 1, 1, 4'hF, ad, 36'h0);
        chk({pOut, dOut}, memModel[ad]);
        chk(dOeN, 1'b0);
    endtask

    function automatic logic [7:0] nxt(input logic [7:0] ad, input logic [1:0] n);
        return {ad[7:2], md ? ad[1:0] ^ n : ad[1:0] + n};
    endfunction

    // ----
    // scenarios
    // ----
    task automatic t_lanes;
        for (int m = 0; m < 16; m++) begin
            cyc(1, 0, 1, 0, 1, 4'hF, 8'(m + 32), 36'hF_FFFF_FFFF);
            chk(op, SBSD_BEGIN_WR);
            chk(dOeN, 1'b1);
            cyc(1, 0, 1, 1, 0, ~4'(m), 8'(m + 32), {4'(m), {4{8'(m * 17)}}});
            chk(op, (m == 0) ? SBSD_BEGIN_RD : SBSD_BEGIN_WR);
            rd(8'(m + 32));
        end
    endtask

    task automatic t_proc;
        cyc(1, 0, 1, 0, 1, 4'hF, 8'h40, 36'h3_0102_0304);
        cyc(0, 1, 1, 0, 0, 4'h0, 8'h40, 36'hC_AAAA_AAAA);
        chk(op, SBSD_BEGIN_RD);
        cyc(1, 1, 1, 1, 0, 4'hE, 8'h40, 36'hC_5555_5555);
        chk(op, SBSD_SUSP_WR);
        rd(8'h40);
    endtask

    task automatic t_burst;
        for (int k = 0; k < 2; k++) begin
            md = k[0];
            for (int n = 0; n < 4; n++) begin
                cyc(1, 0, 1, 0, 1, 4'hF, 8'(80 + n), 36'h5_1234_5678 + 36'(n * 9 + k));
            end
            rd(8'h51);
            for (int n = 1; n < 4; n++) begin
                cyc(1, 1, 0, 1, 1, 4'hF, 8'h00, 36'h0);
                chk(op, SBSD_CONT_RD);
                chk({pOut, dOut}, memModel[nxt(8'h51, 2'(n))]);
            end
            cyc(1, 0, 1, 0, 1, 4'hF, 8'h52, 36'hA_0000_0000);
            for (int n = 1; n < 4; n++) begin
                cyc(1, 1, 0, 0, 1, 4'hF, nxt(8'h52, 2'(n)), 36'hA_0000_0000 + 36'(n + 4 * k));
                chk(op, SBSD_CONT_WR);
            end
            for (int n = 0; n < 4; n++) begin
                rd(8'(80 + n));
            end
        end
    endtask

    task automatic t_offs;
        rd(8'h21);
        oeN = 1'b1;
        #1;
        chk(dOeN, 1'b1);
        zz = 1'b1;
        oeN = 1'b0;
        #1;
        chk(pOeN, 1'b1);
        cyc(1, 0, 1, 1, 1, 4'hF, 8'h00, 36'h0);
        chk(op, SBSD_SLEEP);
        zz = 1'b0;
        s1N = 1'b1;
        cyc(1, 0, 1, 0, 1, 4'hF, 8'h21, 36'h0);
        chk(op, SBSD_DESELECT);
        s1N = 1'b0;
        s2 = 1'b0;
        cyc(0, 1, 1, 1, 1, 4'hF, 8'h00, 36'h0);
        chk(op, SBSD_DESELECT);
        chk(dOeN, 1'b1);
        s2 = 1'b1;
        rd(8'h21);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // hang guard
    initial begin
        #100000;
        err_count++;
        results();
    end

    initial begin
        {srst, s2, pN, cN, vN, gN, bN} = 7'h7F;
        {s1N, s3N, zz, md, oeN, drv} = 6'h00;
        lN = 4'hF;
        a = 8'h00;
        wr = 36'h0;
        err_count = 0;
        tests_run = 0;
        repeat (6) @(posedge clk);
        #1;
        srst = 1'b0;
        chk({pOut, dOut}, 36'h0);
        chk({op, dOeN}, {3'h0, 1'b1});
        t_lanes();
        t_proc();
        t_burst();
        t_offs();
        results();
    end
endmodule

`default_nettype wire
